// file: acop_aux_port.sv
// Overview of operation
// - sixteen aux lines; index n from 1 to 16 drives line n
// - per-line write ON drives high, OFF low; all low after reset
// - per-line query selects a line by index and reports its state
// - per-line query returns 1 for high, 0 for low
// - byte write selector 1 or 2 chooses the affected byte
// - byte query returns ascii text in decimal, binary or hex radix
// - selectors 1 and 2 address distinct bytes, both readable back
//
// Purpose: auxiliary control output port on the rear connector
// Assumes: command strobes are single-cycle pulses from the parser
// Notes:   out-of-range indices or selectors are ignored, query gives 0
`timescale 1ns/1ps
module acop_aux_port #(
    parameter int LINES = acop_pkg::LINE_COUNT
) (
    input  wire logic                          clock,
    input  wire logic                          srst,
    input  wire logic                          auxLineWriteCmd,
    input  wire logic [acop_pkg::IDX_WIDTH-1:0] lineIndex,
    input  wire logic                          lineValue,
    input  wire logic                          auxOctetWriteCmd,
    input  wire logic [1:0]                    octetSel,
    input  wire logic [7:0]                    octetValue,
    input  wire logic                          lineQuery,
    input  wire logic [acop_pkg::IDX_WIDTH-1:0] queryIndex,
    output logic                               lineState,
    output logic                               lineStateValid,
    input  wire logic                          octetQuery,
    input  wire logic [1:0]                    octetQuerySel,
    input  wire acop_pkg::acop_radix_e         replyRadixSetting,
    output logic [8*acop_pkg::TEXT_CHARS-1:0]  octetText,
    output logic [3:0]                         octetTextLen,
    output logic                               octetTextValid,
    output logic [LINES-1:0]                   auxRearConnector
);
    logic [LINES-1:0] aux_r;
    logic [LINES-1:0] aux_nxt;
    logic             lineState_r;
    logic             lineValid_r;
    logic [7:0]       octetPick;
    logic             octetOk;

    wire lineHit  = auxLineWriteCmd && lineIndex >= 5'd1
                    && lineIndex <= 5'(LINES);
    wire [acop_pkg::IDX_WIDTH-1:0] lineBit = lineIndex - 5'd1;
    wire octLow   = auxOctetWriteCmd && octetSel == acop_pkg::BYTE_SEL_LOW;
    wire octHigh  = auxOctetWriteCmd && octetSel == acop_pkg::BYTE_SEL_HIGH;
    wire qHit     = queryIndex >= 5'd1 && queryIndex <= 5'(LINES);
    wire [acop_pkg::IDX_WIDTH-1:0] qBit = queryIndex - 5'd1;

    // per-bit and per-byte writes share one state; a same-cycle collision
    // lets the per-bit write land last, since it is the finer request
    generate
        for (genvar n = 0; n < LINES; n++)
        begin : g_line
            always_comb
            begin
                aux_nxt[n] = aux_r[n];
                if (octLow && n < 8)
                    aux_nxt[n] = octetValue[n % 8];
                if (octHigh && n >= 8)
                    aux_nxt[n] = octetValue[n % 8];
                if (lineHit && lineBit == n)
                    aux_nxt[n] = lineValue;
            end
        end
    endgenerate

    assign octetOk   = octetQuerySel == acop_pkg::BYTE_SEL_LOW
                       || octetQuerySel == acop_pkg::BYTE_SEL_HIGH;
    assign octetPick = (octetQuerySel == acop_pkg::BYTE_SEL_HIGH)
                       ? aux_r[15:8] : aux_r[7:0];

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            aux_r       <= acop_pkg::LINES_RESET;
            lineState_r <= 1'b0;
            lineValid_r <= 1'b0;
        end
        else
        begin
            aux_r       <= aux_nxt;
            lineValid_r <= lineQuery;
            if (lineQuery)
                lineState_r <= qHit && aux_r[qBit[3:0]];
        end
    end

    assign auxRearConnector = aux_r;
    assign lineState        = lineState_r;
    assign lineStateValid   = lineValid_r;

    // unknown selector formats as zero rather than stalling the reply
    acop_text_fmt u_fmt (
        .clock   (clock),
        .srst    (srst),
        .start   (octetQuery),
        .value   (octetOk ? octetPick : 8'h00),
        .radix   (replyRadixSetting),
        .text    (octetText),
        .textLen (octetTextLen),
        .done    (octetTextValid)
    );

    line_write_a: assert property
        (@(posedge clock) disable iff (srst)
        lineHit |=> auxRearConnector[$past(lineBit[3:0])]
                    == $past(lineValue))
        else $error("line write not applied");

    line_others_a: assert property
        (@(posedge clock) disable iff (srst)
        lineHit && !auxOctetWriteCmd |=>
            ((auxRearConnector ^ $past(auxRearConnector))
             & ~(16'h0001 << $past(lineBit[3:0]))) == 16'h0000)
        else $error("line write touched other lines");

    octet_low_a: assert property
        (@(posedge clock) disable iff (srst)
        octLow && !lineHit |=> auxRearConnector[7:0] == $past(octetValue))
        else $error("low byte write not applied");

    octet_keep_a: assert property
        (@(posedge clock) disable iff (srst)
        octLow && !lineHit |=> $stable(auxRearConnector[15:8]))
        else $error("low byte write touched high byte");

    octet_high_a: assert property
        (@(posedge clock) disable iff (srst)
        octHigh && !lineHit |=> auxRearConnector[15:8] == $past(octetValue)
            && $stable(auxRearConnector[7:0]))
        else $error("high byte write wrong");

    bad_index_a: assert property
        (@(posedge clock) disable iff (srst)
        auxLineWriteCmd && !lineHit && !auxOctetWriteCmd
            |=> $stable(auxRearConnector))
        else $error("out of range line write applied");

    bad_octet_a: assert property
        (@(posedge clock) disable iff (srst)
        auxOctetWriteCmd && !octLow && !octHigh && !auxLineWriteCmd
            |=> $stable(auxRearConnector))
        else $error("bad byte selector applied");

    query_reply_a: assert property
        (@(posedge clock) disable iff (srst)
        lineQuery && qHit |=> lineStateValid
            && lineState == $past(aux_r[qBit[3:0]]))
        else $error("line query reply wrong");

    query_range_a: assert property
        (@(posedge clock) disable iff (srst)
        lineQuery && !qHit |=> lineStateValid && !lineState)
        else $error("bad index query not zero");

    query_pulse_a: assert property
        (@(posedge clock) disable iff (srst)
        !lineQuery |=> !lineStateValid)
        else $error("spurious query reply");

    query_hold_a: assert property
        (@(posedge clock) disable iff (srst)
        !lineQuery |=> $stable(lineState))
        else $error("query answer moved");

    hold_idle_a: assert property
        (@(posedge clock) disable iff (srst)
        !auxLineWriteCmd && !auxOctetWriteCmd |=> $stable(auxRearConnector))
        else $error("lines moved without command");

    reset_low_a: assert property
        (@(posedge clock)
        srst |=> auxRearConnector == acop_pkg::LINES_RESET)
        else $error("lines not low after reset");

    reset_reply_a: assert property
        (@(posedge clock)
        srst |=> !lineStateValid && !octetTextValid && !lineState)
        else $error("reply pending after reset");

    text_ready_a: assert property
        (@(posedge clock) disable iff (srst)
        octetQuery |=> octetTextValid && octetTextLen != 4'h0)
        else $error("byte query reply missing");

    text_pulse_a: assert property
        (@(posedge clock) disable iff (srst)
        !octetQuery |=> !octetTextValid)
        else $error("spurious byte reply");

    text_hold_a: assert property
        (@(posedge clock) disable iff (srst)
        !octetQuery |=> $stable(octetText) && $stable(octetTextLen))
        else $error("byte reply text moved");

    bin_len_a: assert property
        (@(posedge clock) disable iff (srst)
        octetQuery && replyRadixSetting == acop_pkg::RADIX_BIN
            |=> octetTextLen == 4'h8)
        else $error("binary reply length wrong");

    hex_len_a: assert property
        (@(posedge clock) disable iff (srst)
        octetQuery && replyRadixSetting == acop_pkg::RADIX_HEX
            |=> octetTextLen == 4'h2)
        else $error("hex reply length wrong");

    dec_len_a: assert property
        (@(posedge clock) disable iff (srst)
        octetQuery && replyRadixSetting == acop_pkg::RADIX_DEC
            |=> octetTextLen >= 4'h1 && octetTextLen <= 4'h3)
        else $error("decimal reply length wrong");

    bad_sel_reply_a: assert property
        (@(posedge clock) disable iff (srst)
        octetQuery && !octetOk && replyRadixSetting == acop_pkg::RADIX_DEC
            |=> octetText[7:0] == acop_pkg::ASCII_ZERO
                && octetTextLen == 4'h1)
        else $error("bad selector reply not zero");
endmodule : acop_aux_port

// file: acop_pkg.sv
// Purpose: shared constants for the auxiliary control output port
// Assumes: 16 lines split into two bytes
// Notes:   radix codes select text formatting of byte readback
package acop_pkg;
    localparam int           LINE_COUNT   = 16;
    localparam int           BYTE_WIDTH   = 8;
    localparam int           IDX_WIDTH    = 5;
    localparam logic [15:0]  LINES_RESET  = 16'h0000;
    localparam logic [1:0]   BYTE_SEL_LOW = 2'h1;
    localparam logic [1:0]   BYTE_SEL_HIGH = 2'h2;
    localparam int           TEXT_CHARS   = 8;
    localparam logic [7:0]   ASCII_ZERO   = 8'h30;
    localparam logic [7:0]   ASCII_A      = 8'h41;
    localparam logic [7:0]   ASCII_SPACE  = 8'h20;
    typedef enum logic [1:0] {
        RADIX_DEC,
        RADIX_BIN,
        RADIX_HEX
    } acop_radix_e;
endpackage : acop_pkg

// file: acop_text_fmt.sv
// Purpose: render one byte as ascii text, right aligned, space padded
// Assumes: radix held steady while start is pulsed
// Notes:   result registered; ready one cycle after start
`timescale 1ns/1ps
module acop_text_fmt (
    input  wire logic                          clock,
    input  wire logic                          srst,
    input  wire logic                          start,
    input  wire logic [7:0]                    value,
    input  wire acop_pkg::acop_radix_e         radix,
    output logic      [8*acop_pkg::TEXT_CHARS-1:0] text,
    output logic      [3:0]                    textLen,
    output logic                               done
);
    logic [8*acop_pkg::TEXT_CHARS-1:0] textNxt;
    logic [3:0]                        lenNxt;
    logic [7:0]                        hundreds;
    logic [7:0]                        tens;
    logic [7:0]                        ones;

    function automatic logic [7:0] hexChar(input logic [3:0] n);
        hexChar = (n < 4'hA) ? acop_pkg::ASCII_ZERO + {4'h0, n}
                             : acop_pkg::ASCII_A + {4'h0, n} - 8'h0A;
    endfunction : hexChar

    assign hundreds = value / 8'd100;
    assign tens     = (value / 8'd10) % 8'd10;
    assign ones     = value % 8'd10;

    always_comb
    begin
        textNxt = {acop_pkg::TEXT_CHARS{acop_pkg::ASCII_SPACE}};
        lenNxt  = 4'h0;
        unique case (radix)
            acop_pkg::RADIX_BIN:
            begin
                for (int i = 0; i < 8; i++)
                    textNxt[8*i +: 8] = acop_pkg::ASCII_ZERO + {7'h0, value[i]};
                lenNxt = 4'h8;
            end
            acop_pkg::RADIX_HEX:
            begin
                textNxt[7:0]  = hexChar(value[3:0]);
                textNxt[15:8] = hexChar(value[7:4]);
                lenNxt = 4'h2;
            end
            default:
            begin
                // leading zeros suppressed for decimal
                textNxt[7:0] = acop_pkg::ASCII_ZERO + ones;
                lenNxt = 4'h1;
                if (value >= 8'd10)
                begin
                    textNxt[15:8] = acop_pkg::ASCII_ZERO + tens;
                    lenNxt = 4'h2;
                end
                if (value >= 8'd100)
                begin
                    textNxt[23:16] = acop_pkg::ASCII_ZERO + hundreds;
                    lenNxt = 4'h3;
                end
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            text    <= '0;
            textLen <= 4'h0;
            done    <= 1'b0;
        end
        else
        begin
            done <= start;
            if (start)
            begin
                text    <= textNxt;
                textLen <= lenNxt;
            end
        end
    end
endmodule : acop_text_fmt

// file: acop_accessory_model.sv
// Purpose: accessory model that reads the aux control lines
// Assumes: lines are static levels sampled on the clock
// Notes:   read only; it never drives the connector back
`timescale 1ns/1ps
module acop_accessory_model (
    input  wire logic        clock,
    input  wire logic [15:0] lines,
    output logic      [15:0] seenLines
);
    // latched like a relay bank, so glitches between edges go unseen
    always_ff @(posedge clock)
    begin
        seenLines <= lines;
    end
endmodule : acop_accessory_model

// file: acop_aux_port_tb.sv
// Purpose: self-checking bench for the aux control output port
// Assumes: strobes driven at the falling edge, one cycle wide
// Notes:   random indices include refused values 0 and 17
`timescale 1ns/1ps
module acop_aux_port_tb;
    logic        clock, srst, lineWr, lineVal, octWr, lineQ, octQ;
    logic [4:0]  lineIdx, qIdx;
    logic [1:0]  octSel, qSel;
    logic [7:0]  octVal;
    logic        lineState, lineStateValid, octetTextValid;
    logic [63:0] octetText;
    logic [3:0]  octetTextLen;
    logic [15:0] lines, seenLines;
    logic [15:0] model = 16'h0000;
    logic [31:0] rng = 32'h0000_0045;
    int          fails = 0;
    int          samples_checked = 0;
    acop_pkg::acop_radix_e radix;

    acop_aux_port i_acop_aux_port (.clock(clock), .srst(srst),
        .auxLineWriteCmd(lineWr), .lineIndex(lineIdx), .lineValue(lineVal),
        .auxOctetWriteCmd(octWr), .octetSel(octSel), .octetValue(octVal),
        .lineQuery(lineQ), .queryIndex(qIdx), .lineState(lineState),
        .lineStateValid(lineStateValid), .octetQuery(octQ),
        .octetQuerySel(qSel), .replyRadixSetting(radix),
        .octetText(octetText), .octetTextLen(octetTextLen),
        .octetTextValid(octetTextValid), .auxRearConnector(lines));
    acop_accessory_model i_acop_accessory_model (.clock(clock),
        .lines(lines), .seenLines(seenLines));

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // text with least significant digit first, spaces beyond the length
    function automatic logic [67:0] fmt(input int v, input int r);
        logic [63:0] t;
        int          x, b, n, d, len;
        t = {8{acop_pkg::ASCII_SPACE}};
        b = (r == 1) ? 2 : (r == 2) ? 16 : 10;
        n = (r == 1) ? 8 : (r == 2) ? 2 : 0;
        x = v;
        len = 0;
        for (int i = 0; i < 8; i++)
        begin
            d = x % b;
            if (i < n || (n == 0 && (x > 0 || i == 0)))
            begin
                t[i*8+:8] = (d < 10) ? acop_pkg::ASCII_ZERO + 8'(d)
                                     : acop_pkg::ASCII_A + 8'(d - 10);
                len++;
            end
            x = x / b;
        end
        return {4'(len), t};
    endfunction : fmt

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // each task starts and ends at a falling edge
    task automatic wrLine(input int i, input logic v);
        {lineWr, lineIdx, lineVal} = {1'b1, 5'(i), v};
        @(negedge clock);
        lineWr = 1'b0;
        if (i >= 1 && i <= 16)
            model[i-1] = v;
        chk(64'(lines), 64'(model));
    endtask : wrLine

    task automatic qLine(input int i);
        {lineQ, qIdx} = {1'b1, 5'(i)};
        @(negedge clock);
        lineQ = 1'b0;
        chk(64'(lineStateValid), 64'h1);
        chk(64'(lineState), (i >= 1 && i <= 16) ? 64'(model[i-1]) : 0);
    endtask : qLine

    task automatic wrByte(input int s, input logic [7:0] v);
        {octWr, octSel, octVal} = {1'b1, 2'(s), v};
        @(negedge clock);
        octWr = 1'b0;
        if (s == 1)
            model[7:0] = v;
        if (s == 2)
            model[15:8] = v;
        chk(64'(lines), 64'(model));
    endtask : wrByte

    task automatic qByte(input int s, input int r);
        logic [67:0] e;
        e = fmt((s == 1) ? model[7:0] : (s == 2) ? model[15:8] : 0, r);
        {octQ, qSel, radix} = {1'b1, 2'(s), acop_pkg::acop_radix_e'(r)};
        @(negedge clock);
        octQ = 1'b0;
        chk(64'(octetTextValid), 64'h1);
        chk(octetText, e[63:0]);
        chk(64'(octetTextLen), 64'(e[67:64]));
    endtask : qByte

    initial
    begin
        {srst, lineWr, lineVal, octWr, lineQ, octQ} = 6'h3f & 6'h20;
        {lineIdx, qIdx, octSel, qSel, octVal} = 22'h00_0000;
        radix = acop_pkg::RADIX_DEC;
        repeat (4) @(negedge clock);
        srst = 1'b0;
        chk(64'(lines), 64'h0);
        chk(octetText, 64'h0);
        for (int k = 0; k < 60; k++)
        begin
            rng = xs(rng);
            if (k == 30)
            begin
                srst = 1'b1;
                @(negedge clock);
                srst = 1'b0;
                model = 16'h0000;
                chk(64'(lines), 64'h0);
                chk(64'(lineState), 64'h0);
            end
            wrLine(rng[4:0] % 18, rng[8]);
            qLine(rng[13:9] % 18);
            chk(64'(seenLines), 64'(model));
            wrByte(rng[17:16], rng[31:24]);
            qByte(rng[19:18], rng[21:20] % 3);
        end
        end_sim();
    end

    // loop needs about 245 cycles; the limit leaves wide margin
    initial
    begin
        #20000;
        fails++;
        end_sim();
    end
endmodule : acop_aux_port_tb
